// ---- rtl/i2c_subaddr_defs.vh ----
// Constants for the serial subaddress register port.
`ifndef I2C_SUBADDR_DEFS_VH
`define I2C_SUBADDR_DEFS_VH

`define SLAVE_WR_DEFAULT 8'h42
`define SLAVE_WR_ALT 8'h40
`define SLAVE_RD_DEFAULT 8'h43
`define SLAVE_RD_ALT 8'h41

`define SUB_CHIP_VERSION 8'h00
`define SUB_FRONT_FIRST 8'h01
`define SUB_DECODER_LAST 8'h19
`define SUB_DECODER_STATUS 8'h1F
`define SUB_AUDIO_FIRST 8'h30
`define SUB_AUDIO_LAST 8'h3A
`define SUB_SLICER_FIRST 8'h40
`define SUB_SLICER_LAST 8'h5E
`define SUB_SLSTAT_FIRST 8'h60
`define SUB_SLSTAT_MID 8'h61
`define SUB_SLSTAT_LAST 8'h62
`define SUB_GLOBAL_FIRST 8'h80
`define SUB_GLOBAL_LAST 8'h8F
`define SUB_TASKA_FIRST 8'h90
`define SUB_TASKA_LAST 8'hBF
`define SUB_TASKB_FIRST 8'hC0
`define SUB_TASKB_LAST 8'hEF

`define RESERVED_READ 8'h00
`define POINTER_RESET 8'h00

`define CLOCK_KHZ 50000
`define MAX_RATE_KBPS 400
`define HOLD_DIVISOR 8

`endif

// ---- rtl/bit_sync.v ----
// Two flip-flop synchroniser for a group of asynchronous inputs.
`default_nettype none
module bit_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/setting_ram.v ----
// Byte-wide setting memory with a registered read port.
`default_nettype none
module setting_ram #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_write,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  output reg [DATA_W-1:0] o_rdata
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge i_clock) begin
    if (i_write) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= {DATA_W{1'b0}};
    end else begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/i2c_subaddress_register_port.v ----
// Serial two-wire slave giving access to the byte-wide subaddress space.
`include "i2c_subaddr_defs.vh"
`default_nettype none
module i2c_subaddress_register_port #(
  parameter [3:0] CHIP_VERSION_ID = 4'h1
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  input wire i_address_select_strap,
  input wire [7:0] i_decoder_status,
  input wire [7:0] i_slicer_status_0,
  input wire [7:0] i_slicer_status_1,
  input wire [7:0] i_slicer_status_2,
  output reg o_reg_wr_strobe,
  output reg [7:0] o_reg_wr_addr,
  output reg [7:0] o_reg_wr_data
);
  // The chip version nibble is arbitrary.
  localparam integer BIT_CYCLES = `CLOCK_KHZ / `MAX_RATE_KBPS;
  localparam integer HOLD_CYCLES = BIT_CYCLES / `HOLD_DIVISOR;
  localparam [7:0] HOLD_LOAD = HOLD_CYCLES[7:0];

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_SUB = 4'h3;
  localparam [3:0] ST_SUB_ACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  reg [1:0] rst_sync_q;
  wire rst_n;
  wire [2:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire strap_s;
  reg scl_prev_q;
  reg sda_prev_q;
  reg [1:0] strap_wait_q;
  reg alt_addr_q;
  reg [3:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg sda_low_q;
  reg [7:0] hold_cnt_q;
  reg ram_we_q;
  reg [7:0] ram_wdata_q;
  wire [7:0] ram_rdata;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire act_fall;
  wire [7:0] wr_addr_byte;
  wire [7:0] rd_addr_byte;
  reg writable;
  reg [7:0] rd_byte;

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  bit_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'b111)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_reset_n(rst_n),
    .i_async({i_address_select_strap, i_sda, i_scl}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[2];

  // The strap is taken once, after the synchroniser has flushed its reset
  // pattern, so the pin level and not the reset value picks the pair.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_q <= 2'b00;
      alt_addr_q <= 1'b0;
    end else if (strap_wait_q != 2'b11) begin
      strap_wait_q <= strap_wait_q + 2'b01;
      if (strap_wait_q == 2'b10) begin
        alt_addr_q <= strap_s;
      end
    end
  end

  assign wr_addr_byte = alt_addr_q ? `SLAVE_WR_ALT : `SLAVE_WR_DEFAULT;
  assign rd_addr_byte = alt_addr_q ? `SLAVE_RD_ALT : `SLAVE_RD_DEFAULT;

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Output changes wait a fraction of the shortest bit after SCL falls,
  // which keeps data hold time at the fastest permitted rate.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_q <= 8'h00;
    end else if (scl_fall) begin
      hold_cnt_q <= HOLD_LOAD;
    end else if (hold_cnt_q != 8'h00) begin
      hold_cnt_q <= hold_cnt_q - 8'h01;
    end
  end
  assign act_fall = (hold_cnt_q == 8'h01) & ~scl_s;

  always @* begin
    writable = 1'b0;
    if (ptr_q >= `SUB_FRONT_FIRST && ptr_q <= `SUB_DECODER_LAST) begin
      writable = 1'b1;
    end
    if (ptr_q >= `SUB_AUDIO_FIRST && ptr_q <= `SUB_AUDIO_LAST) begin
      writable = 1'b1;
    end
    if (ptr_q >= `SUB_SLICER_FIRST && ptr_q <= `SUB_SLICER_LAST) begin
      writable = 1'b1;
    end
    if (ptr_q >= `SUB_GLOBAL_FIRST && ptr_q <= `SUB_GLOBAL_LAST) begin
      writable = 1'b1;
    end
    if (ptr_q >= `SUB_TASKA_FIRST && ptr_q <= `SUB_TASKB_LAST) begin
      writable = 1'b1;
    end
  end

  always @* begin
    if (writable) begin
      rd_byte = ram_rdata;
    end else if (ptr_q == `SUB_CHIP_VERSION) begin
      rd_byte = {CHIP_VERSION_ID, 4'h0};
    end else if (ptr_q == `SUB_DECODER_STATUS) begin
      rd_byte = i_decoder_status;
    end else if (ptr_q == `SUB_SLSTAT_FIRST) begin
      rd_byte = i_slicer_status_0;
    end else if (ptr_q == `SUB_SLSTAT_MID) begin
      rd_byte = i_slicer_status_1;
    end else if (ptr_q == `SUB_SLSTAT_LAST) begin
      rd_byte = i_slicer_status_2;
    end else begin
      rd_byte = `RESERVED_READ;
    end
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= `POINTER_RESET;
      sda_low_q <= 1'b0;
      ram_we_q <= 1'b0;
      ram_wdata_q <= 8'h00;
    end else begin
      ram_we_q <= 1'b0;
      if (start_seen) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_low_q <= 1'b0;
      end else if (stop_seen) begin
        state_q <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_rise && state_q != ST_IDLE) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (act_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              if (shift_q == wr_addr_byte || shift_q == rd_addr_byte) begin
                sda_low_q <= 1'b1;
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_q <= 4'h0;
            // The acknowledge bit has been shifted in on top of the address,
            // so the direction bit now sits one place up.
            if (shift_q[1]) begin
              tx_q <= {rd_byte[6:0], 1'b0};
              sda_low_q <= ~rd_byte[7];
              state_q <= ST_RDATA;
            end else begin
              sda_low_q <= 1'b0;
              state_q <= ST_SUB;
            end
          end
          ST_SUB: begin
            if (bit_cnt_q == 4'h8) begin
              ptr_q <= shift_q;
              sda_low_q <= 1'b1;
              state_q <= ST_SUB_ACK;
            end
          end
          ST_SUB_ACK, ST_WACK: begin
            bit_cnt_q <= 4'h0;
            sda_low_q <= 1'b0;
            state_q <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt_q == 4'h8) begin
              ram_we_q <= writable;
              ram_wdata_q <= shift_q;
              ptr_q <= ptr_q + 8'h01;
              sda_low_q <= 1'b1;
              state_q <= ST_WACK;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_q == 4'h8) begin
              sda_low_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= ST_RACK;
            end else begin
              sda_low_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bit_cnt_q <= 4'h0;
            if (shift_q[0]) begin
              state_q <= ST_IDLE;
            end else begin
              tx_q <= {rd_byte[6:0], 1'b0};
              sda_low_q <= ~rd_byte[7];
              state_q <= ST_RDATA;
            end
          end
          default: begin
            sda_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // The write lands one cycle after the pointer has moved on, so the
  // memory address is held back to the byte that was received.
  reg [7:0] wr_ptr_q;
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 8'h00;
      o_reg_wr_strobe <= 1'b0;
      o_reg_wr_addr <= 8'h00;
      o_reg_wr_data <= 8'h00;
    end else begin
      wr_ptr_q <= ptr_q;
      o_reg_wr_strobe <= ram_we_q;
      if (ram_we_q) begin
        o_reg_wr_addr <= wr_ptr_q;
        o_reg_wr_data <= ram_wdata_q;
      end
    end
  end

  setting_ram #(
    .ADDR_W(8),
    .DATA_W(8)
  ) u_ram (
    .i_clock(i_clock),
    .i_reset_n(rst_n),
    .i_write(ram_we_q),
    .i_addr(ram_we_q ? wr_ptr_q : ptr_q),
    .i_wdata(ram_wdata_q),
    .o_rdata(ram_rdata)
  );

  assign o_sda = 1'b0;
  assign o_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ---- tb/i2c_subaddress_register_port_properties.sv ----
// Assertions on the serial register port pins.
`default_nettype none
module i2c_subaddress_register_port_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_reg_wr_strobe,
  input wire logic [7:0] o_reg_wr_addr,
  input wire logic [7:0] o_reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  a_strobe_pulse: assert property (o_reg_wr_strobe |=>
    (!o_reg_wr_strobe) [*8]) else $error("strobe too long");
  a_strobe_in_ack: assert property (o_reg_wr_strobe |-> o_sda_oe)
    else $error("strobe outside ack");
  a_status_kept: assert property (o_reg_wr_strobe |->
    o_reg_wr_addr != 8'h1F) else $error("status written");
  a_slstat_kept: assert property (o_reg_wr_strobe |->
    !(o_reg_wr_addr inside {[8'h60:8'h62]})) else $error("slicer status");
  a_reserved_dropped: assert property (o_reg_wr_strobe |->
    o_reg_wr_addr inside {[8'h01:8'h19], [8'h30:8'h3A], [8'h40:8'h5E],
    [8'h80:8'hEF]}) else $error("read-only place written");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data moved with clock high");
  a_wr_hold: assert property (!o_reg_wr_strobe |->
    $stable(o_reg_wr_addr) && $stable(o_reg_wr_data))
    else $error("write outputs moved");
  a_open_drain: assert property (o_sda == 1'b0)
    else $error("data pin driven high");
endmodule
bind i2c_subaddress_register_port
  i2c_subaddress_register_port_properties u_props (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_reg_wr_strobe(o_reg_wr_strobe),
  .o_reg_wr_addr(o_reg_wr_addr), .o_reg_wr_data(o_reg_wr_data));
`default_nettype wire

// ---- tb/i2c_master_model.sv ----
// Behavioural bus master driving the serial clock and data.
`default_nettype none
module i2c_master_model #(
  parameter int Q = 32
) (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic w(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // A bit lasts 4*Q clocks, 2.56 us, so the rate stays under 400 kbit/s.
  task automatic start();
    o_sda_low <= 1'b0;
    w(Q);
    o_scl <= 1'b1;
    w(Q);
    o_sda_low <= 1'b1;
    w(Q);
    o_scl <= 1'b0;
    w(Q);
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    w(Q);
    o_scl <= 1'b1;
    w(Q);
    o_sda_low <= 1'b0;
    w(2 * Q);
  endtask
  task automatic shift_bit(input logic b, output logic r);
    o_sda_low <= ~b;
    w(Q);
    o_scl <= 1'b1;
    w(Q);
    r = i_sda;
    w(Q);
    o_scl <= 1'b0;
    w(Q);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m_ack,
    output logic [7:0] r, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      shift_bit(d[i], r[i]);
    shift_bit(m_ack, x);
    ack = ~x;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_i2c_subaddress_register_port.sv ----
// Self-checking bench for the serial register port.
`default_nettype none
module test_i2c_subaddress_register_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic scl, sda_low, oe, strobe, a, ak, wx;
  logic [7:0] waddr, wdata, sub, d, e, rd;
  logic [7:0] got [3];
  wire logic sda_line;
  int n_mismatch = 0;
  int check_count = 0;
  int n_strobe = 0;
  int n0;
  logic [24:0] rows [7] = '{
    {1'b0, 8'h00, 8'h55, 8'h10},
    {1'b1, 8'h01, 8'hA5, 8'hA5}, {1'b1, 8'h5E, 8'h3C, 8'h3C},
    {1'b1, 8'h8F, 8'hF8, 8'hF8}, {1'b1, 8'hC0, 8'h0C, 8'h0C},
    {1'b0, 8'h1F, 8'h55, 8'h96}, {1'b0, 8'h62, 8'h22, 8'hC7}};
  assign sda_line = ~(sda_low | oe);
  always #10 clk = ~clk;
  always @(posedge clk)
    if (strobe === 1'b1)
      n_strobe <= n_strobe + 1;
  i2c_subaddress_register_port dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda_line),
    .o_sda(), .o_sda_oe(oe), .i_address_select_strap(strap),
    .i_decoder_status(8'h96), .i_slicer_status_0(8'h5A),
    .i_slicer_status_1(8'h3C), .i_slicer_status_2(8'hC7),
    .o_reg_wr_strobe(strobe), .o_reg_wr_addr(waddr), .o_reg_wr_data(wdata));
  i2c_master_model m (.i_clock(clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda_low(sda_low));
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wrn(input logic [7:0] dev, s, v, input int n, input logic p);
    m.start();
    m.xfer(dev, 1'b1, rd, a);
    for (int i = 0; i <= n; i++) begin
      m.xfer(i > 0 ? 8'(v + i - 1) : s, 1'b1, rd, ak);
      a &= ak;
    end
    if (p)
      m.stop();
  endtask
  task automatic rdn(input logic [7:0] dev, s, input int n);
    wrn(dev, s, 8'h00, 0, 1'b0);
    m.start();
    m.xfer(dev | 8'h01, 1'b1, rd, ak);
    for (int i = 0; i < n; i++)
      m.xfer(8'hFF, i == n - 1, got[i], ak);
    m.stop();
  endtask
  task automatic rst(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  initial begin
    #1960000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst(1'b0);
    foreach (rows[k]) begin
      {wx, sub, d, e} = rows[k];
      n0 = n_strobe;
      wrn(8'h42, sub, d, 1, 1'b1);
      chk({7'h0, a}, 8'h01);
      chk(8'(n_strobe - n0), {7'h0, wx});
      if (wx)
        chk(wdata, d);
      rdn(8'h42, sub, 1);
      chk(got[0], e);
    end
    n0 = n_strobe;
    wrn(8'h42, 8'h5E, 8'hA0, 3, 1'b1);
    chk(8'(n_strobe - n0), 8'h01);
    chk(waddr, 8'h5E);
    rdn(8'h42, 8'h5E, 3);
    chk(got[0], 8'hA0);
    chk(got[1], 8'h00);
    chk(got[2], 8'h5A);
    wrn(8'h44, 8'h01, 8'h77, 1, 1'b1);
    chk({7'h0, a}, 8'h00);
    rst(1'b1);
    wrn(8'h40, 8'h90, 8'h5C, 1, 1'b1);
    chk({7'h0, a}, 8'h01);
    rdn(8'h40, 8'h90, 1);
    chk(got[0], 8'h5C);
    wrn(8'h42, 8'h90, 8'h11, 1, 1'b1);
    chk({7'h0, a}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
